// file: rx_status_map.svh
// Offsets, field positions and reset values of the receiver status readout
`ifndef RX_STATUS_MAP_SVH
`define RX_STATUS_MAP_SVH
`define REG_CTRL_OFF        8'h2A
`define REG_CODE_OFF        8'h2B
`define REG_READOUT_OFF     8'h2C
`define REG_STRENGTH_OFF    8'h2D
`define REG_GAIN_OFF        8'h2E
`define REG_IRQ_STATUS_OFF  8'h30
`define REG_IRQ_MASK_OFF    8'h31
`define CTRL_MODE_BIT       7
`define READOUT_LIMIT_BIT   0
`define IRQ_ADJUST_BIT      0
`define IRQ_LIMIT_BIT       1
`define IRQ_PEAK_BIT        2
`define IRQ_W               3
`define CODE_RESET          4'h0
`define STRENGTH_RESET      4'h0
`define IRQ_MASK_RESET      3'h0
`endif

// file: rx_status_pkg.sv
// Types shared by the receiver status readout
package rx_status_pkg;
    typedef logic [3:0] nibble_t;
    typedef struct packed {
        nibble_t am;
        nibble_t pm;
    } chan_pair_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;
endpackage : rx_status_pkg

// file: peak_hold.sv
// Peak hold of one channel strength code
`timescale 1ns/100ps
`include "rx_status_map.svh"
module peak_hold
    import rx_status_pkg::*;
#(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Sample and control
    input  wire logic         sample_valid,
    input  wire logic [W-1:0] sample,
    input  wire logic         restart,
    // Held peak
    output logic      [W-1:0] peak,
    output logic              raised
);
    logic [W-1:0] peak_r;
    logic [W-1:0] peak_nxt;
    logic         raised_nxt;

    always_comb begin
        peak_nxt   = peak_r;
        raised_nxt = 1'b0;
        if (restart) begin
            peak_nxt = W'(`STRENGTH_RESET);
        // [R11] Keep maximum only
        end else if (sample_valid && (sample > peak_r)) begin
            peak_nxt   = sample;
            raised_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            peak_r <= W'(`STRENGTH_RESET);
            raised <= 1'b0;
        end else begin
            peak_r <= peak_nxt;
            raised <= raised_nxt;
        end
    end

    assign peak = peak_r;

    // [R11] Peak never drops except on restart
    chk_peak_monotone: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        !$past(restart) |-> (peak_r >= $past(peak_r))) else $error("peak dropped without restart");
endmodule : peak_hold

// file: receiver_status_readout.sv
// Receiver status readout registers with peak hold and interrupt
// ***************************************************************
// Overview of operation
// [R1] Readout bits 7:4 show code from last regulator-adjust command.
// [R2] Readout bit 0 is high while supply regulator is in current limit.
// [R3] Strength bits 7:4 hold AM peak until reception start or clear.
// [R4] Strength bits 3:0 hold PM peak until reception start or clear.
// [R5] Gain bits 7:4 show total AM stage two/three gain reduction.
// [R6] Gain bits 3:0 show total PM gain reduction, gain config encoding.
// [R7] Regulator code is linear 0.1 V steps; low codes undefined 3.3 V.
// [R8] Strength code zero means at or below lowest threshold.
// [R9] Mode bit picks adjust result (0) or written code (1).
// [R10] Written code uses the same encoding as the readout field.
// [R11] Strength field only rises during a reception, keeping the maximum.
// [R12] Reserved readout bits read zero; writes to readouts are ignored.
// ***************************************************************
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "rx_status_map.svh"
module receiver_status_readout
    import rx_status_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Regulator analog side
    input  wire logic       adjust_done,
    input  wire logic [3:0] adjust_code,
    input  wire logic       current_limit_pin,
    output logic      [3:0] regulator_code,
    // Receiver analog side
    input  wire logic       rx_start,
    input  wire logic       strength_clear,
    input  wire logic       strength_valid,
    input  wire logic [3:0] am_strength,
    input  wire logic [3:0] pm_strength,
    input  wire logic [3:0] am_gain_reduction_state,
    input  wire logic [3:0] pm_gain_reduction_state,
    // Interrupt
    output logic            irq
);
    // ***************************************************************
    // Input synchronisers
    // ***************************************************************
    logic [1:0] limit_sync_r;
    logic       limit_d_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            limit_sync_r <= 2'h0;
            limit_d_r    <= 1'b0;
        end else begin
            limit_sync_r <= {limit_sync_r[0], current_limit_pin};
            limit_d_r    <= limit_sync_r[1];
        end
    end

    wire limit_s    = limit_sync_r[1];
    wire limit_rise = limit_s & ~limit_d_r;

    // ***************************************************************
    // Regulator code state
    // ***************************************************************
    bus_req_t req;
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    nibble_t adj_code_r, adj_code_nxt;
    nibble_t ext_code_r, ext_code_nxt;
    logic    mode_r, mode_nxt;

    always_comb begin
        adj_code_nxt = adj_code_r;
        ext_code_nxt = ext_code_r;
        mode_nxt     = mode_r;
        // [R1] Capture adjust result
        if (adjust_done) begin
            adj_code_nxt = adjust_code;
        end
        if (req.wr && req.addr == `REG_CTRL_OFF) begin
            mode_nxt = req.wdata[`CTRL_MODE_BIT];
        end
        // [R10] Written code same encoding
        if (req.wr && req.addr == `REG_CODE_OFF) begin
            ext_code_nxt = req.wdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adj_code_r <= `CODE_RESET;
            ext_code_r <= `CODE_RESET;
            mode_r     <= 1'b0;
        end else begin
            adj_code_r <= adj_code_nxt;
            ext_code_r <= ext_code_nxt;
            mode_r     <= mode_nxt;
        end
    end

    // [R9] Mode selects code source
    // [R7] Code passes unchanged
    assign regulator_code = mode_r ? ext_code_r : adj_code_r;

    // ***************************************************************
    // Peak hold per channel
    // ***************************************************************
    chan_pair_t peak;
    logic [1:0] raised;
    logic       restart;
    nibble_t    samples [2];
    nibble_t    peaks   [2];

    // [R3] Restart on reception or clear
    assign restart    = rx_start | strength_clear;
    assign samples[0] = am_strength;
    assign samples[1] = pm_strength;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_peak
            peak_hold #(.W(4)) u_peak (
                .clk          (clk),
                .rst_n        (rst_n),
                .sample_valid (strength_valid),
                .sample       (samples[ch]),
                .restart      (restart),
                .peak         (peaks[ch]),
                .raised       (raised[ch])
            );
        end
    endgenerate

    // [R4] Both channel fields
    // [R8] Zero after restart
    assign peak = '{am: peaks[0], pm: peaks[1]};

    // ***************************************************************
    // Interrupt status and mask
    // ***************************************************************
    logic [`IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
    logic [`IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
    logic [`IRQ_W-1:0] irq_set;

    always_comb begin
        irq_set                  = '0;
        irq_set[`IRQ_ADJUST_BIT] = adjust_done;
        irq_set[`IRQ_LIMIT_BIT]  = limit_rise;
        irq_set[`IRQ_PEAK_BIT]   = |raised;
        irq_stat_nxt = irq_stat_r;
        if (req.rd && req.addr == `REG_IRQ_STATUS_OFF) begin
            irq_stat_nxt = '0;
        end
        irq_stat_nxt = irq_stat_nxt | irq_set;
        irq_mask_nxt = irq_mask_r;
        if (req.wr && req.addr == `REG_IRQ_MASK_OFF) begin
            irq_mask_nxt = req.wdata[`IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= '0;
            irq_mask_r <= `IRQ_MASK_RESET;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ***************************************************************
    // Read data
    // ***************************************************************
    logic [7:0] rdata_nxt;

    always_comb begin
        rdata_nxt = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                `REG_CTRL_OFF:       rdata_nxt = {mode_r, 7'h00};
                `REG_CODE_OFF:       rdata_nxt = {4'h0, ext_code_r};
                // [R1] Code in upper nibble
                // [R2] Limit flag bit 0
                // [R12] Reserved bits zero
                `REG_READOUT_OFF:    rdata_nxt = {adj_code_r, 3'h0, limit_s};
                // [R3] AM upper, PM lower
                `REG_STRENGTH_OFF:   rdata_nxt = peak;
                // [R5] AM gain upper nibble
                // [R6] PM gain lower nibble
                `REG_GAIN_OFF:       rdata_nxt = {am_gain_reduction_state, pm_gain_reduction_state};
                `REG_IRQ_STATUS_OFF: rdata_nxt = {5'h00, irq_stat_r};
                `REG_IRQ_MASK_OFF:   rdata_nxt = {5'h00, irq_mask_r};
                default:             rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rdata_nxt;
        end
    end

    // ***************************************************************
    // Checks
    // ***************************************************************
    sequence s_rd_readout;
        rd && addr == `REG_READOUT_OFF;
    endsequence

    sequence s_limit_high;
        current_limit_pin [*3];
    endsequence

    sequence s_limit_low;
        (!current_limit_pin) [*3];
    endsequence

    // [R9] Written code in use
    chk_code_select: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
        wr && addr == `REG_CODE_OFF && mode_r |=> {4'h0, regulator_code} == ($past(wdata) & 8'h0F))
        else $error("regulator code source wrong");
    // [R1] Adjust result shown
    chk_adjust_code: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        adjust_done && !mode_r && !(wr && addr == `REG_CTRL_OFF) |=> regulator_code == $past(adjust_code))
        else $error("adjust code not shown");
    // [R1] Readout shows adjust result
    chk_readout_code: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        s_rd_readout |=> rdata[7:4] == $past(adj_code_r))
        else $error("readout code wrong");
    // [R2] Limit flag in readout
    chk_limit_flag: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        s_rd_readout |=> rdata[0] == $past(limit_s)) else $error("limit flag wrong");
    // [R2] Limit follows steady pin
    chk_limit_high: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        s_limit_high |-> limit_s)
        else $error("limit flag not raised");
    // [R2] Limit drops with pin
    chk_limit_low: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        s_limit_low |-> !limit_s)
        else $error("limit flag not dropped");
    // [R12] Reserved bits zero
    chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        s_rd_readout |=> rdata[3:1] == 3'h0) else $error("reserved bits not zero");
    // [R3] Restart clears peaks
    chk_peak_restart: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        restart |=> peak == 8'h00) else $error("peak not cleared");
    // [R11] Higher sample is stored
    chk_peak_raise: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        strength_valid && !restart && (pm_strength > peak.pm) |=> peak.pm == $past(pm_strength))
        else $error("higher strength not stored");
    // [R4] Strength readout value
    chk_strength_read: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        rd && addr == `REG_STRENGTH_OFF |=> rdata == $past(peak)) else $error("strength read wrong");
    // [R5] Gain readout value
    chk_gain_read: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
        rd && addr == `REG_GAIN_OFF |=> rdata[7:4] == $past(am_gain_reduction_state)
        && rdata[3:0] == $past(pm_gain_reduction_state)) else $error("gain read wrong");
    // [R12] Writes leave readouts
    chk_readout_write: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        wr && addr == `REG_STRENGTH_OFF && !restart && !strength_valid |=> $stable(peak))
        else $error("write changed readout");
    // Read data zero without read
    chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !rd |=> rdata == 8'h00)
        else $error("read data not idle");
    // Event wins over read clear
    chk_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        irq_set != '0 |=> (irq_stat_r & $past(irq_set)) == $past(irq_set))
        else $error("interrupt status not set");
endmodule : receiver_status_readout

// file: tb_top.sv
// Self-checking testbench of the receiver status readout
`timescale 1ns/100ps
`include "rx_status_map.svh"
module tb_top
    import rx_status_pkg::*;
;
    typedef struct packed {
        nibble_t    am;
        nibble_t    pm;
        logic [7:0] exp;
    } row_t;
    logic       clk, rst_n, wr, rd, adjust_done, current_limit_pin;
    logic       rx_start, strength_clear, strength_valid, irq;
    logic [7:0] addr, wdata, rdata;
    logic [3:0] adjust_code, regulator_code, am_strength, pm_strength;
    logic [3:0] am_gain_reduction_state, pm_gain_reduction_state;
    int         mismatches, compares;
    row_t       rows [5] = '{'{4'h0, 4'h0, 8'h00}, '{4'hF, 4'h0, 8'hF0}, '{4'h0, 4'hF, 8'h0F},
                             '{4'hA, 4'h5, 8'hA5}, '{4'h3, 4'hC, 8'h3C}};

    receiver_status_readout i_dut (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .adjust_done(adjust_done), .adjust_code(adjust_code), .current_limit_pin(current_limit_pin),
        .regulator_code(regulator_code), .rx_start(rx_start), .strength_clear(strength_clear),
        .strength_valid(strength_valid), .am_strength(am_strength), .pm_strength(pm_strength),
        .am_gain_reduction_state(am_gain_reduction_state),
        .pm_gain_reduction_state(pm_gain_reduction_state), .irq(irq));

    // ************************
    // Compare and bus tasks
    // ************************
    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        cmp_val(rdata, exp);
    endtask : reg_rd

    task automatic sample(input logic [3:0] am, input logic [3:0] pm);
        @(posedge clk);
        am_strength    <= am;
        pm_strength    <= pm;
        strength_valid <= 1'b1;
        @(posedge clk);
        strength_valid <= 1'b0;
    endtask : sample

    task automatic end_of_test;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // ************************
    // Clock, watchdog, tests
    // ************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #(100 * 3000);
        mismatches++;
        end_of_test();
    end

    initial begin
        {rst_n, wr, rd, adjust_done, current_limit_pin, rx_start, strength_clear, strength_valid} = '0;
        {addr, wdata, adjust_code, am_strength, pm_strength} = '0;
        {am_gain_reduction_state, pm_gain_reduction_state} = '0;
        mismatches = 0;
        compares   = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        cmp_bit(irq, 1'b0);
        cmp_val({4'h0, regulator_code}, 8'h00);
        reg_rd(`REG_READOUT_OFF, 8'h00);
        reg_rd(`REG_STRENGTH_OFF, 8'h00);
        reg_rd(`REG_IRQ_MASK_OFF, 8'h00);
        // Gain state live, table rows
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            am_gain_reduction_state <= rows[i].am;
            pm_gain_reduction_state <= rows[i].pm;
            reg_rd(`REG_GAIN_OFF, rows[i].exp);
        end
        // Adjust result, masked then unmasked interrupt
        @(posedge clk);
        adjust_code <= 4'h9;
        adjust_done <= 1'b1;
        @(posedge clk);
        adjust_done <= 1'b0;
        #1;
        cmp_bit(irq, 1'b0);
        reg_wr(`REG_IRQ_MASK_OFF, 8'h07);
        cmp_bit(irq, 1'b1);
        reg_rd(`REG_IRQ_MASK_OFF, 8'h07);
        reg_rd(`REG_IRQ_STATUS_OFF, 8'h01);
        cmp_bit(irq, 1'b0);
        reg_rd(`REG_READOUT_OFF, 8'h90);
        cmp_val({4'h0, regulator_code}, 8'h09);
        // Written code mode
        reg_wr(`REG_CODE_OFF, 8'h05);
        reg_wr(`REG_CTRL_OFF, 8'h80);
        cmp_val({4'h0, regulator_code}, 8'h05);
        reg_rd(`REG_CTRL_OFF, 8'h80);
        reg_wr(`REG_CODE_OFF, 8'h0C);
        cmp_val({4'h0, regulator_code}, 8'h0C);
        reg_rd(`REG_CODE_OFF, 8'h0C);
        reg_rd(`REG_READOUT_OFF, 8'h90);
        reg_wr(`REG_CTRL_OFF, 8'h00);
        cmp_val({4'h0, regulator_code}, 8'h09);
        // Current limit flag
        @(posedge clk);
        current_limit_pin <= 1'b1;
        repeat (4) @(posedge clk);
        reg_rd(`REG_READOUT_OFF, 8'h91);
        cmp_bit(irq, 1'b1);
        @(posedge clk);
        current_limit_pin <= 1'b0;
        repeat (4) @(posedge clk);
        reg_rd(`REG_READOUT_OFF, 8'h90);
        // Peak hold, reception start and clear
        sample(4'h5, 4'h3);
        sample(4'h2, 4'h7);
        reg_rd(`REG_STRENGTH_OFF, 8'h57);
        sample(4'hA, 4'h1);
        reg_rd(`REG_STRENGTH_OFF, 8'hA7);
        @(posedge clk);
        rx_start <= 1'b1;
        @(posedge clk);
        rx_start <= 1'b0;
        reg_rd(`REG_STRENGTH_OFF, 8'h00);
        sample(4'hF, 4'h0);
        reg_rd(`REG_STRENGTH_OFF, 8'hF0);
        @(posedge clk);
        strength_clear <= 1'b1;
        @(posedge clk);
        strength_clear <= 1'b0;
        reg_rd(`REG_STRENGTH_OFF, 8'h00);
        sample(4'h0, 4'h2);
        // Writes to readouts ignored, then checked by reads
        reg_wr(`REG_READOUT_OFF, 8'hFF);
        reg_wr(`REG_STRENGTH_OFF, 8'hFF);
        reg_wr(`REG_GAIN_OFF, 8'hFF);
        reg_rd(`REG_READOUT_OFF, 8'h90);
        reg_rd(`REG_STRENGTH_OFF, 8'h02);
        reg_rd(`REG_GAIN_OFF, 8'h3C);
        reg_rd(8'h7F, 8'h00);
        // Limit and peak events pending, read clears
        reg_rd(`REG_IRQ_STATUS_OFF, 8'h06);
        cmp_bit(irq, 1'b0);
        // Mid-run reset with an event pending
        sample(4'h6, 4'h6);
        @(posedge clk);
        #1;
        cmp_bit(irq, 1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1;
        cmp_bit(irq, 1'b0);
        cmp_val(rdata, 8'h00);
        cmp_val({4'h0, regulator_code}, 8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(`REG_STRENGTH_OFF, 8'h00);
        reg_rd(`REG_READOUT_OFF, 8'h00);
        reg_rd(`REG_IRQ_MASK_OFF, 8'h00);
        end_of_test();
    end
endmodule : tb_top
